// >>> rtl/eac_eeprom_ctrl.sv
// Data EEPROM access controller behind the CPU's I/O register port.
// Assumes clk_i keeps running during rst_i, por_i is the power-on reset
// and osc_clk_i is the calibrated oscillator, asynchronous to clk_i.
//
// Contract
// - Nine-bit address from high bit 0 and low byte; upper high bits read 0.
// - Data register feeds programming, takes read bytes, resets to zero.
// - Mode field picks atomic, erase or write; code 11 reserved.
// - Mode writes are ignored while the program strobe is set.
// - Reset clears the mode field unless programming is in progress.
// - Ready interrupt stays asserted while enabled, globally enabled, not busy.
// - The arm bit clears itself four cycles after being written one.
// - Programming starts only when strobed within the four-cycle arm window.
// - Program strobe reads busy until the mode's time has elapsed.
// - Setting the program strobe stalls the CPU two cycles.
// - Read strobe fetches the byte at once and stalls the CPU four cycles.
// - While busy, reads are refused and the address cannot change.
// - Control bits 7:6 read zero; software writes them zero.
// - Enable, arm and read strobe bits reset to zero.
// - Programming time is counted on the calibrated oscillator.
// - A running program operation survives reset and completes.
`timescale 1ns/1ps
module eac_eeprom_ctrl
    import eac_pkg::*;
#(
    parameter int ATOMIC_TICKS = EAC_ATOMIC_TICKS,
    parameter int SPLIT_TICKS = EAC_SPLIT_TICKS,
    parameter int TMR_W = 16
) (
    // Clock and resets
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic por_i,
    // I/O register port
    input wire logic [5:0] io_addr_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [7:0] io_wdata_i,
    output logic [7:0] io_rdata_o,
    // Core side
    input wire logic core_irq_flag_i,
    output logic cpu_stall_o,
    output logic ready_irq_o,
    // Calibrated oscillator
    input wire logic osc_clk_i
);

    // ========================================================
    // Register port decode
    logic ctrl_wr, data_wr, adrl_wr, adrh_wr;
    logic w_re, w_pe, w_arm, w_rie;
    logic [1:0] w_pm;
    logic arm_q, busy_q, rie_q, rd_pend_q;
    logic [1:0] pm_q;
    logic [7:0] data_q, rdata_q, rd_mux;
    logic [8:0] addr_q;
    logic prog_go, rd_go, arm_load, done;

    assign ctrl_wr = io_wr_i && (io_addr_i == EAC_CTRL_OFS);
    assign data_wr = io_wr_i && (io_addr_i == EAC_DATA_OFS);
    assign adrl_wr = io_wr_i && (io_addr_i == EAC_ADRL_OFS);
    assign adrh_wr = io_wr_i && (io_addr_i == EAC_ADRH_OFS);
    assign w_re = io_wdata_i[EAC_RD_BIT];
    assign w_pe = io_wdata_i[EAC_PS_BIT];
    assign w_arm = io_wdata_i[EAC_ARM_BIT];
    assign w_rie = io_wdata_i[EAC_RIE_BIT];
    assign w_pm = io_wdata_i[EAC_PM_LSB +: 2];

    // ========================================================
    // Start conditions
    // Writing zero to either strobe matches no term below.
    assign prog_go = ctrl_wr && w_pe && arm_q && !busy_q
        && (w_pm != EAC_PM_RSVD);
    assign rd_go = ctrl_wr && w_re && !busy_q && !prog_go;
    assign arm_load = ctrl_wr && w_arm && !prog_go;

    // ========================================================
    // Oscillator synchroniser and tick
    logic [2:0] osc_sync_q;
    logic osc_lvl_q, osc_tick;

    always_ff @(posedge clk_i or posedge por_i) begin
        if (por_i) begin
            osc_sync_q <= 3'h0;
            osc_lvl_q <= 1'b0;
        end else begin
            osc_sync_q <= {osc_sync_q[1:0], osc_clk_i};
            if (osc_sync_q[1] == osc_sync_q[2]) begin
                osc_lvl_q <= osc_sync_q[2];
            end
        end
    end

    assign osc_tick = (osc_sync_q[1] == osc_sync_q[2]) && osc_sync_q[2]
        && !osc_lvl_q;

    // ========================================================
    // Arm window and CPU stall counters
    logic [2:0] arm_cnt, stall_cnt, arm_val, stall_val;
    logic arm_zero, stall_zero;

    assign arm_val = prog_go ? 3'h0 : EAC_ARM_CYC;
    assign stall_val = prog_go ? EAC_PROG_STALL_CYC : EAC_READ_STALL_CYC;

    eac_down_counter #(.W(3)) u_arm_cnt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(arm_load || prog_go),
        .load_val_i(arm_val),
        .en_i(1'b1),
        .count_o(arm_cnt),
        .zero_o(arm_zero)
    );

    eac_down_counter #(.W(3)) u_stall_cnt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(prog_go || rd_go),
        .load_val_i(stall_val),
        .en_i(1'b1),
        .count_o(stall_cnt),
        .zero_o(stall_zero)
    );

    assign arm_q = !arm_zero;
    assign cpu_stall_o = !stall_zero;

    // ========================================================
    // Programming timer on the oscillator, outside system reset
    logic [TMR_W-1:0] tmr_val;
    logic tmr_zero;

    assign tmr_val = (w_pm == EAC_PM_ATOMIC) ? TMR_W'(ATOMIC_TICKS) :
        TMR_W'(SPLIT_TICKS);

    eac_down_counter #(.W(TMR_W)) u_prog_tmr (
        .clk_i(clk_i),
        .rst_i(por_i),
        .load_i(prog_go),
        .load_val_i(tmr_val),
        .en_i(osc_tick),
        .count_o(),
        .zero_o(tmr_zero)
    );

    assign done = busy_q && tmr_zero;

    // ========================================================
    // Operation state, kept through system reset
    // Only power-on clears these, so a reset during programming lets
    // the cell update finish with the latched address and data.
    logic [1:0] op_mode_q;
    logic [8:0] op_addr_q;
    logic [7:0] op_data_q;

    always_ff @(posedge clk_i or posedge por_i) begin
        if (por_i) begin
            busy_q <= 1'b0;
            op_mode_q <= EAC_PM_RST;
            op_addr_q <= EAC_ADDR_RST;
            op_data_q <= EAC_DATA_RST;
        end else begin
            if (prog_go) begin
                busy_q <= 1'b1;
                op_mode_q <= w_pm;
                op_addr_q <= addr_q;
                op_data_q <= data_q;
            end else if (done) begin
                busy_q <= 1'b0;
            end
        end
    end

    // ========================================================
    // Mode field and address registers
    // The mode field reads rst_i synchronously, which is why the clock
    // must keep running while system reset is held.
    always_ff @(posedge clk_i or posedge por_i) begin
        if (por_i) begin
            pm_q <= EAC_PM_RST;
            addr_q <= EAC_ADDR_RST;
        end else begin
            if (rst_i && !busy_q) begin
                pm_q <= EAC_PM_RST;
            end else if (ctrl_wr && !busy_q && !rst_i) begin
                pm_q <= w_pm;
            end
            if (adrl_wr && !busy_q && !rst_i) begin
                addr_q[7:0] <= io_wdata_i;
            end
            if (adrh_wr && !busy_q && !rst_i) begin
                addr_q[8] <= io_wdata_i[0];
            end
        end
    end

    // ========================================================
    // Data, enable and read-back registers
    logic [7:0] arr_rd_data;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            data_q <= EAC_DATA_RST;
            rie_q <= 1'b0;
            rd_pend_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            rd_pend_q <= rd_go;
            if (rd_pend_q) begin
                data_q <= arr_rd_data;
            end else if (data_wr) begin
                data_q <= io_wdata_i;
            end
            if (ctrl_wr) begin
                rie_q <= w_rie;
            end
            if (io_rd_i) begin
                rdata_q <= rd_mux;
            end
        end
    end

    assign rd_mux =
        (io_addr_i == EAC_CTRL_OFS) ?
            {2'h0, pm_q, rie_q, arm_q, busy_q, 1'b0} :
        (io_addr_i == EAC_DATA_OFS) ? data_q :
        (io_addr_i == EAC_ADRL_OFS) ? addr_q[7:0] :
        (io_addr_i == EAC_ADRH_OFS) ? {7'h00, addr_q[8]} :
        8'h00;

    assign io_rdata_o = rdata_q;
    assign ready_irq_o = rie_q && core_irq_flag_i && !busy_q;

    // ========================================================
    // Storage array
    eac_nvm_array #(.AW(9), .DW(8)) u_array (
        .clk_i(clk_i),
        .rd_en_i(rd_go),
        .rd_addr_i(addr_q),
        .rd_data_o(arr_rd_data),
        .cmt_i(done),
        .cmt_mode_i(op_mode_q),
        .cmt_addr_i(op_addr_q),
        .cmt_data_i(op_data_q)
    );

    // ========================================================
    // Assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || por_i);

    sequence arm_quiet_s;
        arm_load ##1 (!ctrl_wr) [*4];
    endsequence

    sequence prog_stall_s;
        cpu_stall_o [*2] ##1 !cpu_stall_o;
    endsequence

    sequence read_stall_s;
        cpu_stall_o [*4] ##1 !cpu_stall_o;
    endsequence

    addr_high_zero_a: assert property (
        $past(io_rd_i && io_addr_i == EAC_ADRH_OFS) |-> io_rdata_o[7:1] == 0
    ) else $error("upper address bits not zero");

    ctrl_rsvd_zero_a: assert property (
        $past(io_rd_i && io_addr_i == EAC_CTRL_OFS) |-> io_rdata_o[7:6] == 0
    ) else $error("control bits 7:6 not zero");

    arm_expire_a: assert property (
        arm_quiet_s |=> !arm_q
    ) else $error("arm bit did not clear after four cycles");

    arm_hold_a: assert property (
        arm_load |=> arm_q
    ) else $error("arm bit not set after write");

    unarmed_start_a: assert property (
        ctrl_wr && w_pe && !arm_q && !busy_q |=> !busy_q
    ) else $error("programming started without arming");

    prog_stall_a: assert property (
        prog_go |=> (busy_q and prog_stall_s)
    ) else $error("program start stall not two cycles");

    read_stall_a: assert property (
        rd_go |=> read_stall_s
    ) else $error("read stall not four cycles");

    read_fetch_a: assert property (
        rd_go |=> ##1 data_q == $past(arr_rd_data)
    ) else $error("read byte not loaded into data register");

    pm_locked_a: assert property (
        busy_q |=> $stable(pm_q)
    ) else $error("mode changed while programming");

    addr_locked_a: assert property (
        busy_q |=> $stable(addr_q)
    ) else $error("address changed while programming");

    ready_irq_a: assert property (
        $fell(busy_q) && rie_q && core_irq_flag_i |-> ready_irq_o
    ) else $error("ready interrupt missing after programming");

    ready_enable_a: assert property (
        (ctrl_wr && w_rie && !busy_q && !prog_go) ##1 core_irq_flag_i
            |-> ready_irq_o
    ) else $error("ready interrupt missing after enable");

    rsvd_mode_a: assert property (
        ctrl_wr && w_pe && w_pm == EAC_PM_RSVD && !busy_q |=> !busy_q
    ) else $error("reserved mode started an operation");

endmodule : eac_eeprom_ctrl

// >>> rtl/eac_pkg.sv
// Constants for the data EEPROM access controller.
// Assumes a 200 MHz I/O clock and an 8 MHz calibrated oscillator input.
package eac_pkg;

    // ========================================================
    // Register offsets on the I/O register port
    localparam logic [5:0] EAC_CTRL_OFS = 6'h1f;
    localparam logic [5:0] EAC_DATA_OFS = 6'h20;
    localparam logic [5:0] EAC_ADRL_OFS = 6'h21;
    localparam logic [5:0] EAC_ADRH_OFS = 6'h22;

    // ========================================================
    // Control register fields
    localparam int EAC_RD_BIT = 0;
    localparam int EAC_PS_BIT = 1;
    localparam int EAC_ARM_BIT = 2;
    localparam int EAC_RIE_BIT = 3;
    localparam int EAC_PM_LSB = 4;

    // ========================================================
    // Programming modes
    localparam logic [1:0] EAC_PM_ATOMIC = 2'h0;
    localparam logic [1:0] EAC_PM_ERASE = 2'h1;
    localparam logic [1:0] EAC_PM_WRITE = 2'h2;
    localparam logic [1:0] EAC_PM_RSVD = 2'h3;

    // ========================================================
    // Reset values
    localparam logic [7:0] EAC_DATA_RST = 8'h00;
    localparam logic [8:0] EAC_ADDR_RST = 9'h000;
    localparam logic [1:0] EAC_PM_RST = EAC_PM_ATOMIC;
    localparam logic [7:0] EAC_ERASED = 8'hff;

    // ========================================================
    // Timing
    localparam int EAC_OSC_PERIOD_NS = 125;
    localparam int EAC_ATOMIC_NS = 3400000;
    localparam int EAC_SPLIT_NS = 1800000;
    localparam int EAC_ATOMIC_TICKS = EAC_ATOMIC_NS / EAC_OSC_PERIOD_NS;
    localparam int EAC_SPLIT_TICKS = EAC_SPLIT_NS / EAC_OSC_PERIOD_NS;
    localparam logic [2:0] EAC_ARM_CYC = 3'h4;
    localparam logic [2:0] EAC_PROG_STALL_CYC = 3'h2;
    localparam logic [2:0] EAC_READ_STALL_CYC = 3'h4;

endpackage : eac_pkg

// >>> rtl/eac_down_counter.sv
// Loadable down counter that stops at zero.
// Assumes load and enable come from logic on clk_i.
`timescale 1ns/1ps
module eac_down_counter #(
    parameter int W = 3
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic load_i,
    input wire logic [W-1:0] load_val_i,
    input wire logic en_i,
    // Status
    output logic [W-1:0] count_o,
    output logic zero_o
);

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    // ========================================================
    // Counter
    assign cnt_d = load_i ? load_val_i :
        ((en_i && cnt_q != '0) ? cnt_q - W'(1) : cnt_q);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign count_o = cnt_q;
    assign zero_o = (cnt_q == '0);

endmodule : eac_down_counter

// >>> rtl/eac_nvm_array.sv
// Storage array of the data EEPROM with registered read port.
// Assumes commits arrive only at the end of a timed programming operation.
`timescale 1ns/1ps
module eac_nvm_array
    import eac_pkg::*;
#(
    parameter int AW = 9,
    parameter int DW = 8
) (
    // Clock
    input wire logic clk_i,
    // Read port
    input wire logic rd_en_i,
    input wire logic [AW-1:0] rd_addr_i,
    output logic [DW-1:0] rd_data_o,
    // Commit port
    input wire logic cmt_i,
    input wire logic [1:0] cmt_mode_i,
    input wire logic [AW-1:0] cmt_addr_i,
    input wire logic [DW-1:0] cmt_data_i
);

    logic [DW-1:0] mem_q [2**AW];
    logic [DW-1:0] rd_q;
    logic [DW-1:0] new_val;

    // ========================================================
    // Cell update
    // A write without a prior erase can only clear bits, so the new byte
    // is ANDed into the old contents, as on real cells.
    assign new_val = (cmt_mode_i == EAC_PM_ERASE) ? DW'(EAC_ERASED) :
        (cmt_mode_i == EAC_PM_WRITE) ? (mem_q[cmt_addr_i] & cmt_data_i) :
        cmt_data_i;

    always_ff @(posedge clk_i) begin
        if (cmt_i) begin
            mem_q[cmt_addr_i] <= new_val;
        end
        if (rd_en_i) begin
            rd_q <= mem_q[rd_addr_i];
        end
    end

    assign rd_data_o = rd_q;

endmodule : eac_nvm_array

// >>> tb/eac_osc_model.sv
// Model of the calibrated oscillator that times programming.
// Assumes a half period of several I/O clock cycles, as the
// controller's synchroniser needs.
`timescale 1ns/1ps
module eac_osc_model #(
    parameter int HALF_NS = 25
) (
    // Oscillator output
    output logic osc_clk_o
);
    // ==========================================================
    // Oscillator
    // It runs free, also across reset, so that a running program
    // operation keeps its time base.
    initial begin
        osc_clk_o = 1'b0;
        forever #(HALF_NS) osc_clk_o = ~osc_clk_o;
    end
endmodule : eac_osc_model

// >>> tb/eac_eeprom_ctrl_tb.sv
// Self-checking bench for the data EEPROM access controller.
// Assumes shortened programming counts and the oscillator model.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module eac_eeprom_ctrl_tb
    import eac_pkg::*;
;
    localparam int AT = 20;
    localparam int ST = 10;
    localparam int OSC_CYC = 10;
    // ==========================================================
    // Stimulus and observed signals
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic por_i = 1'b1;
    logic [5:0] io_addr_i = 6'h00;
    logic io_wr_i = 1'b0;
    logic io_rd_i = 1'b0;
    logic [7:0] io_wdata_i = 8'h00;
    logic core_irq_flag_i = 1'b0;
    logic [7:0] io_rdata_o;
    logic cpu_stall_o;
    logic ready_irq_o;
    logic osc_clk_i;
    int n_fail = 0;
    int checks = 0;
    int cyc = 0;
    logic [31:0] seed = 32'd44;
    logic [7:0] mem [0:511];
    always #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) cyc <= cyc + 1;
    eac_osc_model #(.HALF_NS(25)) eac_osc_model_i (.osc_clk_o(osc_clk_i));
    eac_eeprom_ctrl #(.ATOMIC_TICKS(AT), .SPLIT_TICKS(ST)) eac_eeprom_ctrl_i (
        .clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .io_addr_i(io_addr_i),
        .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i),
        .io_rdata_o(io_rdata_o), .core_irq_flag_i(core_irq_flag_i),
        .cpu_stall_o(cpu_stall_o), .ready_irq_o(ready_irq_o),
        .osc_clk_i(osc_clk_i));
    // ==========================================================
    // Reference functions
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    // Write-only can only clear bits, so it ANDs into the old byte.
    function automatic logic [7:0] prog_val(logic [1:0] m, logic [7:0] o,
                                            logic [7:0] d);
        case (m)
            EAC_PM_ATOMIC: return d;
            EAC_PM_ERASE: return EAC_ERASED;
            EAC_PM_WRITE: return o & d;
            default: return o;
        endcase
    endfunction : prog_val
    // ==========================================================
    // Register port tasks
    task automatic finish_test();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_i);
        io_addr_i <= a;
        io_wdata_i <= d;
        io_wr_i <= 1'b1;
        @(posedge clk_i);
        io_wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge clk_i);
        io_addr_i <= a;
        io_rd_i <= 1'b1;
        @(posedge clk_i);
        io_rd_i <= 1'b0;
        @(posedge clk_i);
        #1;
        d = io_rdata_o;
    endtask : rd
    task automatic chk_rd(input logic [5:0] a, input logic [7:0] e,
                          input string nm);
        logic [7:0] d;
        rd(a, d);
        `CHK(nm, e, d)
    endtask : chk_rd
    task automatic stall_cnt(output int n);
        n = 0;
        repeat (8) begin
            #1;
            if (cpu_stall_o !== 1'b0) n++;
            @(posedge clk_i);
        end
    endtask : stall_cnt
    task automatic wait_idle(input int t0, output int dur);
        logic [7:0] c;
        for (int i = 0; i < 1000; i++) begin
            rd(EAC_CTRL_OFS, c);
            if (c[EAC_PS_BIT] === 1'b0) begin
                dur = cyc - t0;
                return;
            end
        end
        n_fail++;
        finish_test();
    endtask : wait_idle
    task automatic do_reset();
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask : do_reset
    // ==========================================================
    // One armed programming operation, then a read back
    task automatic prog(input logic [1:0] m, input logic [8:0] a,
                        input logic [7:0] d, input logic mr);
        logic [7:0] c;
        logic [7:0] e;
        logic f;
        int n;
        int t0;
        int dur;
        int lim;
        logic [31:0] rnd;
        e = prog_val(m, mem[a], d);
        lim = ((m == EAC_PM_ATOMIC) ? AT : ST) * OSC_CYC;
        @(posedge clk_i);
        rnd = xs();
        core_irq_flag_i <= rnd[0];
        wr(EAC_ADRL_OFS, a[7:0]);
        wr(EAC_ADRH_OFS, {7'h00, a[8]});
        wr(EAC_DATA_OFS, d);
        wr(EAC_CTRL_OFS, {2'h0, m, 4'h8});
        wr(EAC_CTRL_OFS, {2'h0, m, 4'hc});
        wr(EAC_CTRL_OFS, {2'h0, m, 4'ha});
        t0 = cyc;
        stall_cnt(n);
        `CHK("prog_stall", (m == EAC_PM_RSVD) ? 0 : 2, n)
        if (m == EAC_PM_RSVD) begin
            chk_rd(EAC_CTRL_OFS, 8'h38, "rsvd_idle");
        end else begin
            chk_rd(EAC_CTRL_OFS, {2'h0, m, 4'ha}, "busy");
            `CHK("irq_busy", 1'b0, ready_irq_o)
            wr(EAC_CTRL_OFS, {2'h0, ~m, 4'h9});
            wr(EAC_ADRL_OFS, ~a[7:0]);
            wr(EAC_ADRH_OFS, {7'h00, ~a[8]});
            if (mr)
                do_reset();
            chk_rd(EAC_CTRL_OFS, {2'h0, m, mr ? 4'h2 : 4'ha},
                   "mode_hold");
            chk_rd(EAC_DATA_OFS, mr ? 8'h00 : d, "data_hold");
            chk_rd(EAC_ADRL_OFS, a[7:0], "adrl_hold");
            chk_rd(EAC_ADRH_OFS, {7'h00, a[8]}, "adrh_hold");
            wait_idle(t0, dur);
            `CHK("busy_time", 1'b1, dur >= lim - 10 && dur <= lim + 40)
            f = !mr && core_irq_flag_i;
            `CHK("irq_idle", f, ready_irq_o)
        end
        mem[a] = e;
        wr(EAC_CTRL_OFS, 8'h01);
        stall_cnt(n);
        `CHK("rd_stall", 4, n)
        chk_rd(EAC_DATA_OFS, e, "rd_data");
    endtask : prog
    // ==========================================================
    // Main sequence
    initial begin
        logic [8:0] ad [4];
        logic [31:0] r;
        int n;
        ad = '{9'h000, 9'h1ff, 9'h0a5, 9'h15a};
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        por_i <= 1'b0;
        chk_rd(EAC_CTRL_OFS, 8'h00, "ctrl_rst");
        chk_rd(EAC_DATA_OFS, EAC_DATA_RST, "data_rst");
        wr(EAC_ADRH_OFS, 8'hff);
        chk_rd(EAC_ADRH_OFS, 8'h01, "adrh_mask");
        wr(EAC_CTRL_OFS, 8'h30);
        chk_rd(EAC_CTRL_OFS, 8'h30, "ctrl_top");
        chk_rd(6'h3a, 8'h00, "unmapped");
        wr(EAC_CTRL_OFS, 8'h04);
        chk_rd(EAC_CTRL_OFS, 8'h04, "arm_set");
        chk_rd(EAC_CTRL_OFS, 8'h00, "arm_clr");
        wr(EAC_CTRL_OFS, 8'h02);
        stall_cnt(n);
        `CHK("noarm_stall", 0, n)
        chk_rd(EAC_CTRL_OFS, 8'h00, "noarm_busy");
        wr(EAC_CTRL_OFS, 8'h04);
        repeat (5) @(posedge clk_i);
        wr(EAC_CTRL_OFS, 8'h02);
        chk_rd(EAC_CTRL_OFS, 8'h00, "late_strobe");
        wr(EAC_CTRL_OFS, 8'h18);
        wr(EAC_DATA_OFS, 8'h5a);
        do_reset();
        chk_rd(EAC_CTRL_OFS, 8'h00, "idle_rst");
        chk_rd(EAC_DATA_OFS, 8'h00, "data_clr");
        for (int i = 0; i < 4; i++) begin
            r = xs();
            prog(EAC_PM_ATOMIC, ad[i], r[7:0], 1'b0);
        end
        for (int i = 0; i < 4; i++) begin
            r = xs();
            prog(i[1:0], ad[r[9:8]], r[7:0], i == 2);
        end
        for (int i = 0; i < 10; i++) begin
            r = xs();
            prog(r[11:10], ad[r[9:8]], r[7:0], r[14:12] == 3'h0);
        end
        finish_test();
    end
endmodule : eac_eeprom_ctrl_tb
